// ==== design/cms_pkg.sv ====
// Constants and types of the chopper mode switch and standstill block.
package cms_pkg;
  localparam int THRESH_W             = 20;
  localparam int SCALE_W              = 10;
  localparam int REG_W                = 9;
  localparam int HOLD_W               = 5;
  localparam int DELAY_W              = 8;
  localparam int FS_WIN_W             = 3;
  localparam logic [9:0] SCALE_SUM_LIMIT = 10'h3FF;
  localparam logic [2:0] FS_WINDOW    = 3'h4;
  localparam logic [1:0] SST_NORMAL   = 2'h0;
  localparam logic [1:0] SST_STANDSTILL_OPTION_SELECT = 2'h1;
  localparam logic [1:0] SST_SHORT_LS = 2'h2;
  localparam logic [1:0] SST_SHORT_HS = 2'h3;
  typedef enum logic [1:0] {
    CMS_VOLT = 2'b01,
    CMS_CURR = 2'b10
  } cms_mode_type;
  typedef enum logic [2:0] {
    CMS_RUN     = 3'b001,
    CMS_WAIT_PD = 3'b010,
    CMS_WAIT_HR = 3'b100
  } cms_stst_type;
endpackage : cms_pkg

// ==== design/cms_ol_coil.sv ====
// Per-coil open-load detector for voltage mode.
module cms_ol_coil
  import cms_pkg::*;
(
  // Clock and reset.
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // Status inputs.
  input  wire logic volt_mode_i,
  input  wire logic fullstep_i,
  input  wire logic target_reached_i,
  input  wire logic coil_open_i,
  // Flag.
  output logic      open_load_o
);
  logic [FS_WIN_W-1:0] miss_cnt;

  // The flag looks at a few full steps so that single slow steps do not flicker it.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !volt_mode_i || target_reached_i) begin
      miss_cnt <= '0;
    end else if (fullstep_i && miss_cnt != FS_WINDOW) begin
      miss_cnt <= miss_cnt + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      open_load_o <= 1'b0;
    end else begin
      open_load_o <= volt_mode_i && (coil_open_i || miss_cnt == FS_WINDOW);
    end
  end

  AST_OL_OPEN: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    volt_mode_i && coil_open_i |=> open_load_o)
    else $error("Open coil did not raise the open-load flag.");
endmodule : cms_ol_coil

// ==== design/cms_chopper_mode.sv ====
// Chopper mode selection, regulation hold, open-load flags and standstill options.
// Operation
// - Voltage mode only below the transition velocity, current mode above it.
// - Voltage mode off while measured microstep period is under the threshold.
// - Threshold zero keeps the driver in voltage mode always.
// - With phase matching enabled, measure shift and apply it in current mode.
// - Hold last voltage regulation value and restart from it on return.
// - Open-load flag when regulation missed full current in recent full steps.
// - Interrupted coil keeps its open-load flag asserted in voltage mode.
// - Summed amplitude scale readable; 1023 means current cannot be sustained.
// - Standstill option applies after power-down and hold ramp delays, hold zero.
// - Freeze voltage regulation once target current is zero.
// - Option 0 normal, 1 standstill_option_select, 2 low-side short, 3 high-side short.
module cms_chopper_mode
  import cms_pkg::*;
(
  // Clock and reset.
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  // Configuration.
  input  wire logic [THRESH_W-1:0]   voltage_mode_upper_threshold_i,
  input  wire logic                  phase_shift_match_enable_i,
  input  wire logic [HOLD_W-1:0]     hold_current_setting_i,
  input  wire logic [1:0]            standstill_option_select_i,
  input  wire logic [DELAY_W-1:0]    power_down_delay_i,
  input  wire logic [DELAY_W-1:0]    hold_ramp_delay_i,
  // Motion status.
  input  wire logic [THRESH_W-1:0]   measured_microstep_period_i,
  input  wire logic                  standstill_i,
  input  wire logic                  delay_tick_i,
  input  wire logic                  fullstep_i,
  input  wire logic                  target_current_zero_i,
  // Regulator and load detector.
  input  wire logic                  reg_update_i,
  input  wire logic [REG_W-1:0]      reg_value_i,
  input  wire logic [SCALE_W-1:0]    scale_sum_i,
  input  wire logic                  phase_valid_i,
  input  wire logic [7:0]            phase_shift_i,
  input  wire logic                  reached_a_i,
  input  wire logic                  reached_b_i,
  input  wire logic                  coil_open_a_i,
  input  wire logic                  coil_open_b_i,
  // Outputs.
  output logic                       volt_mode_o,
  output logic                       reg_freeze_o,
  output logic [REG_W-1:0]           reg_start_o,
  output logic                       reg_load_o,
  output logic                       phase_apply_o,
  output logic [7:0]                 phase_offset_o,
  output logic [SCALE_W-1:0]         summed_amplitude_scale_o,
  output logic                       scale_limit_o,
  output logic                       open_load_coil_a_o,
  output logic                       open_load_coil_b_o,
  output logic [1:0]                 standstill_drive_o
);
  import cms_pkg::*;

  cms_mode_type mode;
  cms_stst_type stst;
  logic         fast;
  logic [DELAY_W-1:0] dly_cnt;
  logic         hold_zero;

  // Threshold zero never counts as fast, so voltage mode stays selected.
  assign fast = (voltage_mode_upper_threshold_i != '0) &&
                (measured_microstep_period_i < voltage_mode_upper_threshold_i);
  assign hold_zero = (hold_current_setting_i == '0);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mode <= CMS_VOLT;
    end else begin
      case (mode)
        CMS_VOLT: if (fast)  mode <= CMS_CURR;
        CMS_CURR: if (!fast) mode <= CMS_VOLT;
        default:  mode <= CMS_VOLT;
      endcase
    end
  end
  assign volt_mode_o = (mode == CMS_VOLT);

  // The stored value is the restart point, so it is only written in voltage mode.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reg_start_o <= '0;
      reg_load_o  <= 1'b0;
    end else begin
      if (mode == CMS_VOLT && reg_update_i && !reg_freeze_o) begin
        reg_start_o <= reg_value_i;
      end
      reg_load_o <= (mode == CMS_CURR) && !fast;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reg_freeze_o <= 1'b0;
    end else begin
      reg_freeze_o <= target_current_zero_i;
    end
  end

  // The shift is caught on each phase_valid_i in voltage mode and kept until voltage mode returns.
  // Apply rises and falls on the same edges as the mode, so it never leaks into voltage mode.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      phase_offset_o <= 8'h00;
      phase_apply_o  <= 1'b0;
    end else if (mode == CMS_VOLT) begin
      if (phase_valid_i) begin
        phase_offset_o <= phase_shift_i;
      end
      phase_apply_o <= fast && phase_shift_match_enable_i;
    end else if (!fast) begin
      phase_apply_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      summed_amplitude_scale_o <= '0;
      scale_limit_o            <= 1'b0;
    end else begin
      summed_amplitude_scale_o <= scale_sum_i;
      scale_limit_o            <= (scale_sum_i == SCALE_SUM_LIMIT);
    end
  end

  cms_ol_coil u_ol_a (
    .ref_clk_i       (ref_clk_i),
    .reset_i         (reset_i),
    .volt_mode_i     (volt_mode_o),
    .fullstep_i      (fullstep_i),
    .target_reached_i(reached_a_i),
    .coil_open_i     (coil_open_a_i),
    .open_load_o     (open_load_coil_a_o)
  );

  cms_ol_coil u_ol_b (
    .ref_clk_i       (ref_clk_i),
    .reset_i         (reset_i),
    .volt_mode_i     (volt_mode_o),
    .fullstep_i      (fullstep_i),
    .target_reached_i(reached_b_i),
    .coil_open_i     (coil_open_b_i),
    .open_load_o     (open_load_coil_b_o)
  );

  // Standstill sequencing: power-down delay, then hold ramp delay, in ticks.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !standstill_i || !hold_zero) begin
      stst    <= CMS_RUN;
      dly_cnt <= '0;
    end else begin
      case (stst)
        CMS_RUN: begin
          stst    <= CMS_WAIT_PD;
          dly_cnt <= '0;
        end
        CMS_WAIT_PD: if (delay_tick_i) begin
          if (dly_cnt >= power_down_delay_i) begin
            stst    <= CMS_WAIT_HR;
            dly_cnt <= '0;
          end else begin
            dly_cnt <= dly_cnt + 8'h01;
          end
        end
        CMS_WAIT_HR: if (delay_tick_i && dly_cnt < hold_ramp_delay_i) begin
          dly_cnt <= dly_cnt + 8'h01;
        end
        default: stst <= CMS_RUN;
      endcase
    end
  end

  // The options act only in voltage mode; current mode keeps normal drive.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      standstill_drive_o <= SST_NORMAL;
    end else if (standstill_i && hold_zero && stst == CMS_WAIT_HR &&
                 dly_cnt >= hold_ramp_delay_i && volt_mode_o) begin
      case (standstill_option_select_i)
        SST_STANDSTILL_OPTION_SELECT: standstill_drive_o <= SST_STANDSTILL_OPTION_SELECT;
        SST_SHORT_LS:  standstill_drive_o <= SST_SHORT_LS;
        SST_SHORT_HS:  standstill_drive_o <= SST_SHORT_HS;
        default:       standstill_drive_o <= SST_NORMAL;
      endcase
    end else begin
      standstill_drive_o <= SST_NORMAL;
    end
  end

  AST_ZERO_THRESH: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    voltage_mode_upper_threshold_i == '0 && volt_mode_o |=> volt_mode_o)
    else $error("Zero threshold left voltage mode.");
  AST_TO_CURR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    volt_mode_o && fast |=> !volt_mode_o)
    else $error("Fast stepping did not leave voltage mode.");
  AST_TO_VOLT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !volt_mode_o && !fast |=> volt_mode_o)
    else $error("Slow stepping did not return to voltage mode.");
  AST_HOLD_REG: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !volt_mode_o |=> $stable(reg_start_o))
    else $error("Stored regulation value changed in current mode.");
  AST_FREEZE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    target_current_zero_i |=> reg_freeze_o)
    else $error("Regulation not frozen at zero target current.");
  AST_SCALE_LIM: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    scale_sum_i == SCALE_SUM_LIMIT |=> scale_limit_o &&
      summed_amplitude_scale_o == SCALE_SUM_LIMIT)
    else $error("Scale limit not reported.");
  AST_PHASE_CURR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    phase_apply_o |-> !volt_mode_o)
    else $error("Phase shift applied outside current mode.");
  AST_STST_RUN: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !standstill_i |=> standstill_drive_o == SST_NORMAL)
    else $error("Standstill option active while moving.");
  AST_STST_HOLD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !hold_zero |=> standstill_drive_o == SST_NORMAL)
    else $error("Standstill option active with nonzero hold current.");
  AST_STST_DELAY: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(standstill_i) |=> standstill_drive_o == SST_NORMAL [*2])
    else $error("Standstill option applied before the delays.");
endmodule : cms_chopper_mode

// ==== bench/cms_coil_model.sv ====
// Behavioural model of the two motor coils behind the bridges.
module cms_coil_model (
  // Clock and controls from the bench.
  input  wire logic ref_clk_i,
  input  wire logic step_en_i,
  input  wire logic weak_i,
  input  wire logic open_a_i,
  input  wire logic open_b_i,
  // Coil feedback.
  output logic      fullstep_o,
  output logic      reached_a_o,
  output logic      reached_b_o,
  output logic      coil_open_a_o,
  output logic      coil_open_b_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt = 2'h0;
  // A full step every fourth cycle while the motor turns.
  always @(posedge ref_clk_i) begin
    cnt        <= step_en_i ? cnt + 2'h1 : 2'h0;
    fullstep_o <= step_en_i && cnt == 2'h3;
  end
  // An open coil or a weak supply never reaches full current.
  assign reached_a_o   = !weak_i && !open_a_i;
  assign reached_b_o   = !weak_i && !open_b_i;
  assign coil_open_a_o = open_a_i;
  assign coil_open_b_o = open_b_i;
endmodule : cms_coil_model

// ==== bench/chopper_mode_switch_standstill_test.sv ====
// Self-checking bench of the chopper mode switch and standstill block.
module chopper_mode_switch_standstill_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cms_pkg::*;
  logic clk = 0, rst = 1, pme = 1, sst = 0, tz = 0, upd = 0, en = 0, wk = 0, oa = 0, ob = 0;
  logic pv = 0;
  logic [7:0] psh = 8'h00;
  logic [THRESH_W-1:0] thr = 20'h00064, per = 20'h000C8;
  logic [HOLD_W-1:0] hold = 5'h00;
  logic [1:0] opt = 2'h0, drv;
  logic [REG_W-1:0] rv = 9'h000, rs;
  logic [SCALE_W-1:0] ss = 10'h000, sso;
  logic [7:0] po;
  logic fs, ra, rb, ca, cb, vm, frz, ld, pa, sl, open_load_coil_a, open_load_coil_b, ld_seen = 0;
  int n_fail = 0, checks_done = 0, cycles = 0;
  cms_coil_model coils (.ref_clk_i(clk), .step_en_i(en), .weak_i(wk), .open_a_i(oa),
    .open_b_i(ob), .fullstep_o(fs), .reached_a_o(ra), .reached_b_o(rb),
    .coil_open_a_o(ca), .coil_open_b_o(cb));
  cms_chopper_mode dut (.ref_clk_i(clk), .reset_i(rst), .voltage_mode_upper_threshold_i(thr),
    .phase_shift_match_enable_i(pme), .hold_current_setting_i(hold),
    .standstill_option_select_i(opt), .power_down_delay_i(8'h02), .hold_ramp_delay_i(8'h02),
    .measured_microstep_period_i(per), .standstill_i(sst), .delay_tick_i(1'b1),
    .fullstep_i(fs), .target_current_zero_i(tz), .reg_update_i(upd), .reg_value_i(rv),
    .scale_sum_i(ss), .phase_valid_i(pv), .phase_shift_i(psh), .reached_a_i(ra),
    .reached_b_i(rb), .coil_open_a_i(ca), .coil_open_b_i(cb), .volt_mode_o(vm),
    .reg_freeze_o(frz), .reg_start_o(rs), .reg_load_o(ld), .phase_apply_o(pa),
    .phase_offset_o(po), .summed_amplitude_scale_o(sso), .scale_limit_o(sl),
    .open_load_coil_a_o(open_load_coil_a), .open_load_coil_b_o(open_load_coil_b), .standstill_drive_o(drv));
  initial forever #10 clk = ~clk;
  // The load strobe lasts one cycle, so it is latched here for later inspection.
  always @(posedge clk) begin
    if (ld === 1'b1) ld_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic t_mode();
    rv = 9'h1A5; upd = 1; pv = 1; psh = 8'h5C; cyc(1); upd = 0; pv = 0;
    per = 20'h00032; cyc(3);
    chk(vm, 0);
    chk(pa, 1);
    chk(po, 10'h05C);
    chk(ld_seen, 0);
    rv = 9'h0AA; upd = 1; pv = 1; psh = 8'h33; cyc(1); upd = 0; pv = 0;
    per = 20'h000C8; cyc(3);
    chk(vm, 1);
    chk(pa, 0);
    chk(po, 10'h05C);
    chk(ld_seen, 1);
    chk(rs, 10'h1A5);
    pme = 0; per = 20'h00032; cyc(3);
    chk(vm, 0);
    chk(pa, 0);
    per = 20'h000C8; pme = 1; cyc(3);
    chk(vm, 1);
  endtask : t_mode
  task automatic t_zero();
    thr = 20'h00000; per = 20'h00001; cyc(4);
    chk(vm, 1);
    thr = 20'h00064; per = 20'h000C8;
  endtask : t_zero
  task automatic t_open();
    en = 1; ob = 1; cyc(3);
    chk(open_load_coil_b, 1);
    chk(open_load_coil_a, 0);
    ob = 0; wk = 1; cyc(24);
    chk(open_load_coil_a, 1);
    chk(open_load_coil_b, 1);
    en = 0; wk = 0; cyc(3);
    chk(open_load_coil_a, 0);
    chk(open_load_coil_b, 0);
  endtask : t_open
  task automatic t_scale();
    ss = 10'h3FF; cyc(3);
    chk(sso, SCALE_SUM_LIMIT);
    chk(sl, 1);
    ss = 10'h3FE; cyc(3);
    chk(sl, 0);
    chk(sso, 10'h3FE);
  endtask : t_scale
  task automatic t_stst();
    tz = 1; cyc(3);
    chk(frz, 1);
    rv = 9'h0F0; upd = 1; cyc(1); upd = 0;
    chk(rs, 10'h1A5);
    opt = 2'h1; sst = 1; cyc(5);
    chk(drv, 0);
    for (int i = 0; i < 4; i++) begin
      opt = i[1:0]; cyc(14);
      chk(drv, i[1:0]);
    end
    opt = 2'h3; hold = 5'h01; cyc(3);
    chk(drv, 0);
    hold = 5'h00; sst = 0; tz = 0; cyc(2);
    chk(drv, 0);
  endtask : t_stst
  initial begin
    cyc(6); rst = 0; cyc(1);
    chk(vm, 1);
    chk(drv, 0);
    // The motor stays still while voltage mode settles its first regulation.
    cyc(128);
    t_mode();
    t_zero();
    t_open();
    t_scale();
    t_stst();
    summarize();
  end
endmodule : chopper_mode_switch_standstill_test
